// ===== core/mem_throttle_regs.sv
// throttle, lookahead, window size and capability registers on wishbone
//
// Notes on behaviour
// - read throttle: 00 none, 01 87.5, 10 75, 11 62.5 percent; resets 00
// - write throttle: 00 none, 01 62.5, 10 50, 11 37.5 percent; resets 00
// - with lock set, writes to both throttle fields and lock are ignored
// - lock bit is cleared only by reset, never by a write
// - lookahead bit lets host bus unit look further ahead; resets 0
// - window size bit: 0 gives 64 MB table, 1 gives 32 MB, graphics only
// - capability register is read-only; writes change nothing
// - capability bit 31 reports 133 MHz bus and memory support
// - capability bit 30 reports display cache plus unified memory support
// - capability bit 29 reports agp mode support
// - capability bit 28 reports internal graphics controller support
// - capability version field bits 27:24 reads 0001b
// - capability length field bits 23:16 reads 04h
// - next pointer reads A0h in agp mode, 00h in graphics mode
// - capability code field reads the vendor-dependent capability code
// - capability register reads F104A009h in agp mode after reset with all fuses set
//
// The implementer's own choice: the Wishbone slave port.
`include "mem_throttle_regs.svh"
`default_nettype none
module mem_throttle_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  // feature fuses and mode
  input wire mem_throttle_pkg::cap_fuse_s fuse_i,
  input wire logic agp_graphics_mode_control_i,
  // memory scheduler handshake
  input wire logic rd_req_i,
  input wire logic wr_req_i,
  output logic rd_allow_o,
  output logic wr_allow_o,
  // configuration to the rest of the hub
  output mem_throttle_pkg::misc_cfg_s cfg_o,
  output logic gtt_32mb_o
);

  // -----------------------------------------------------------------
  // bus handshake
  // -----------------------------------------------------------------
  logic access;
  logic hit_misc;
  logic hit_capability_identification;
  logic wr_misc;
  logic rd_cap_q;
  logic rd_misc_q;

  wb_reg_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .access_o(access),
    .ack_o(ack_o)
  );

  assign hit_misc = (adr_i[11:2] == `MT_MISC_IDX);
  assign hit_capability_identification = (adr_i[11:2] == `MT_CAPABILITY_IDENTIFICATION_IDX);
  assign wr_misc = access & we_i & hit_misc & sel_i[0];

  // -----------------------------------------------------------------
  // fuse synchroniser
  // -----------------------------------------------------------------
  mem_throttle_pkg::cap_fuse_s fuse_meta_q;
  mem_throttle_pkg::cap_fuse_s fuse_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_meta_q <= `MT_CAP_FUSE_RESET;
      fuse_q <= `MT_CAP_FUSE_RESET;
    end else begin
      fuse_meta_q <= fuse_i;
      fuse_q <= fuse_meta_q;
    end
  end

  // -----------------------------------------------------------------
  // misc_control_low low byte
  // -----------------------------------------------------------------
  mem_throttle_pkg::misc_cfg_s cfg_q;
  logic [7:0] misc_rd;

  // one process owns the struct; throttle fields and lock freeze once lock is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q.rd_limit <= mem_throttle_pkg::THR_NONE;
      cfg_q.wr_limit <= mem_throttle_pkg::THR_NONE;
      cfg_q.lock <= 1'b0;
      cfg_q.lookahead <= 1'b0;
      cfg_q.win_32mb <= 1'b0;
    end else if (wr_misc) begin
      if (!cfg_q.lock) begin
        cfg_q.rd_limit <= mem_throttle_pkg::throttle_e'(
          dat_i[`MT_RD_THR_HI:`MT_RD_THR_LO]);
        cfg_q.wr_limit <= mem_throttle_pkg::throttle_e'(
          dat_i[`MT_WR_THR_HI:`MT_WR_THR_LO]);
        cfg_q.lock <= dat_i[`MT_LOCK_BIT];
      end
      cfg_q.lookahead <= dat_i[`MT_LOOKAHEAD_BIT];
      cfg_q.win_32mb <= dat_i[`MT_WINSIZE_BIT];
    end
  end

  assign cfg_o = cfg_q;

  // table size only matters in graphics mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gtt_32mb_o <= 1'b0;
    end else begin
      gtt_32mb_o <= cfg_q.win_32mb & agp_graphics_mode_control_i;
    end
  end

  always_comb begin
    misc_rd = `MT_MISC_RESET;
    misc_rd[`MT_RD_THR_HI:`MT_RD_THR_LO] = cfg_q.rd_limit;
    misc_rd[`MT_WR_THR_HI:`MT_WR_THR_LO] = cfg_q.wr_limit;
    misc_rd[`MT_LOCK_BIT] = cfg_q.lock;
    misc_rd[`MT_LOOKAHEAD_BIT] = cfg_q.lookahead;
    misc_rd[`MT_WINSIZE_BIT] = cfg_q.win_32mb;
  end

  // -----------------------------------------------------------------
  // capability_identification (no storage, writes fall away)
  // -----------------------------------------------------------------
  logic [31:0] capability_identification_rd;
  logic [7:0] next_ptr;

  assign next_ptr = agp_graphics_mode_control_i ? `MT_CAP_NEXT_GFX
                                                : `MT_CAP_NEXT_AGP;

  always_comb begin
    capability_identification_rd = 32'h00000000;
    capability_identification_rd[31] = fuse_q.mhz133;
    capability_identification_rd[30] = fuse_q.disp_cache;
    capability_identification_rd[29] = fuse_q.agp;
    capability_identification_rd[28] = fuse_q.igfx;
    capability_identification_rd[27:24] = `MT_CAP_VERSION;
    capability_identification_rd[23:16] = `MT_CAP_LENGTH;
    capability_identification_rd[15:8] = next_ptr;
    capability_identification_rd[7:0] = `MT_CAP_CODE;
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  // unmapped reads answer zero; read data only changes on reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (access && !we_i) begin
      if (hit_misc) begin
        dat_o <= {24'h000000, misc_rd};
      end else if (hit_capability_identification) begin
        dat_o <= capability_identification_rd;
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_cap_q <= 1'b0;
    end else begin
      rd_cap_q <= access & ~we_i & hit_capability_identification;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_misc_q <= 1'b0;
    end else begin
      rd_misc_q <= access & ~we_i & hit_misc;
    end
  end

  // -----------------------------------------------------------------
  // bandwidth throttle enforcement
  // -----------------------------------------------------------------
  logic [3:0] rd_budget;
  logic [3:0] wr_budget;

  always_comb begin
    case (cfg_q.rd_limit)
      mem_throttle_pkg::THR_STEP1: rd_budget = `MT_BUDGET_87;
      mem_throttle_pkg::THR_STEP2: rd_budget = `MT_BUDGET_75;
      mem_throttle_pkg::THR_STEP3: rd_budget = `MT_BUDGET_62;
      default: rd_budget = `MT_BUDGET_FULL;
    endcase
  end

  always_comb begin
    case (cfg_q.wr_limit)
      mem_throttle_pkg::THR_STEP1: wr_budget = `MT_BUDGET_62;
      mem_throttle_pkg::THR_STEP2: wr_budget = `MT_BUDGET_50;
      mem_throttle_pkg::THR_STEP3: wr_budget = `MT_BUDGET_37;
      default: wr_budget = `MT_BUDGET_FULL;
    endcase
  end

  throttle_window u_rd_window (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .budget_i(rd_budget),
    .req_i(rd_req_i),
    .allow_o(rd_allow_o)
  );

  throttle_window u_wr_window (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .budget_i(wr_budget),
    .req_i(wr_req_i),
    .allow_o(wr_allow_o)
  );

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_lock_sticky: assert property (cfg_q.lock |=> cfg_q.lock)
    else $error("lock cleared without reset");

  a_lock_write: assert property (!cfg_q.lock && wr_misc |=>
    cfg_q.lock == $past(dat_i[3]))
    else $error("lock bit not written while unlocked");

  a_locked_frozen: assert property (cfg_q.lock && wr_misc |=>
    $stable(cfg_q.rd_limit) && $stable(cfg_q.wr_limit))
    else $error("throttle field changed while locked");

  a_rd_limit_write: assert property (!cfg_q.lock && wr_misc |=>
    cfg_q.rd_limit == $past(dat_i[7:6]))
    else $error("read throttle not written");

  a_wr_limit_write: assert property (!cfg_q.lock && wr_misc |=>
    cfg_q.wr_limit == $past(dat_i[5:4]))
    else $error("write throttle not written");

  a_lookahead_write: assert property (wr_misc |=>
    cfg_o.lookahead == $past(dat_i[1]))
    else $error("lookahead not taken from write");

  a_win_size_write: assert property (wr_misc |=>
    cfg_o.win_32mb == $past(dat_i[0]))
    else $error("window size bit not taken from write");

  a_gtt_size_out: assert property (##1
    gtt_32mb_o == ($past(cfg_q.win_32mb) && $past(agp_graphics_mode_control_i)))
    else $error("table size output wrong");

  a_gtt_agp_mode: assert property (!agp_graphics_mode_control_i |=>
    !gtt_32mb_o)
    else $error("table size output set in agp mode");

  a_misc_readback: assert property (rd_misc_q |->
    dat_o == {24'h000000, $past(cfg_q[6:2]), 1'b0, $past(cfg_q[1:0])})
    else $error("misc read data does not match the register");

  a_capability_identification_no_write: assert property (access && we_i && hit_capability_identification |=>
    dat_o == $past(dat_o))
    else $error("write to capability changed read data");

  a_capability_identification_next_ptr: assert property (rd_cap_q |->
    dat_o[15:8] == ($past(agp_graphics_mode_control_i) ? 8'h00 : 8'hA0))
    else $error("next pointer wrong for mode");

  a_capability_identification_fixed: assert property (rd_cap_q |->
    dat_o[27:0] == {4'h1, 8'h04, dat_o[15:8], 8'h09})
    else $error("fixed capability fields wrong");

  a_capability_identification_reset: assert property (rd_cap_q && $past(fuse_q) == 4'hF &&
    !$past(agp_graphics_mode_control_i) |-> dat_o == 32'hF104A009)
    else $error("capability reset value wrong");

  a_capability_identification_fuses: assert property (rd_cap_q |->
    dat_o[31:28] == $past(fuse_q))
    else $error("capability bits do not follow fuses");

  c_lock_set: cover property (!cfg_q.lock ##1 cfg_q.lock);
  c_locked_write: cover property (cfg_q.lock && wr_misc);
  c_capability_identification_gfx: cover property (rd_cap_q && dat_o[15:8] == 8'h00);
  c_rd_throttled: cover property (rd_req_i && !rd_allow_o);
  c_wr_throttled: cover property (wr_req_i && !wr_allow_o);

endmodule : mem_throttle_regs
`default_nettype wire

// ===== core/mem_throttle_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MEM_THROTTLE_REGS_SVH
`define MEM_THROTTLE_REGS_SVH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define MT_MISC_IDX 10'h072
`define MT_CAPABILITY_IDENTIFICATION_IDX 10'h088

// -----------------------------------------------------------------
// misc_control_low field positions
// -----------------------------------------------------------------
`define MT_RD_THR_HI 7
`define MT_RD_THR_LO 6
`define MT_WR_THR_HI 5
`define MT_WR_THR_LO 4
`define MT_LOCK_BIT 3
`define MT_LOOKAHEAD_BIT 1
`define MT_WINSIZE_BIT 0
`define MT_MISC_RESET 8'h00

// -----------------------------------------------------------------
// capability_identification fixed fields and reset value
// -----------------------------------------------------------------
`define MT_CAP_VERSION 4'h1
`define MT_CAP_LENGTH 8'h04
`define MT_CAP_NEXT_AGP 8'hA0
`define MT_CAP_NEXT_GFX 8'h00
`define MT_CAP_CODE 8'h09
`define MT_CAP_FUSE_RESET 4'hF
`define MT_CAPABILITY_IDENTIFICATION_RESET 32'hF104A009

// -----------------------------------------------------------------
// throttle measurement window and per-setting budgets (of 8 slots)
// -----------------------------------------------------------------
`define MT_WINDOW_LAST 3'h7
`define MT_BUDGET_FULL 4'h8
`define MT_BUDGET_87 4'h7
`define MT_BUDGET_75 4'h6
`define MT_BUDGET_62 4'h5
`define MT_BUDGET_50 4'h4
`define MT_BUDGET_37 4'h3

`endif

// ===== core/mem_throttle_pkg.sv
// types shared by the throttle and capability register logic
`default_nettype none
package mem_throttle_pkg;

  // -----------------------------------------------------------------
  // throttle settings
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    THR_NONE = 2'b00,
    THR_STEP1 = 2'b01,
    THR_STEP2 = 2'b10,
    THR_STEP3 = 2'b11
  } throttle_e;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    throttle_e rd_limit;
    throttle_e wr_limit;
    logic lock;
    logic lookahead;
    logic win_32mb;
  } misc_cfg_s;

  typedef struct packed {
    logic mhz133;
    logic disp_cache;
    logic agp;
    logic igfx;
  } cap_fuse_s;

endpackage : mem_throttle_pkg
`default_nettype wire

// ===== core/wb_reg_port.sv
// classic wishbone handshake: one access pulse and a registered ack
`default_nettype none
module wb_reg_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus strobes
  input wire logic cyc_i,
  input wire logic stb_i,
  // handshake
  output logic access_o,
  output logic ack_o
);

  logic ack_q;

  // one access per request; ack drops in the cycle after it was given
  assign access_o = cyc_i & stb_i & ~ack_q;
  assign ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access_o;
    end
  end

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

endmodule : wb_reg_port
`default_nettype wire

// ===== core/throttle_window.sv
// caps data transfers per fixed window of eight cycles
`include "mem_throttle_regs.svh"
`default_nettype none
module throttle_window (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // budget of transfers per window
  input wire logic [3:0] budget_i,
  // transfer handshake with the memory scheduler
  input wire logic req_i,
  output logic allow_o
);

  logic [2:0] slot_q;
  logic [3:0] used_q;
  logic [3:0] used_d;
  logic allow_q;
  logic take;
  logic wrap;

  assign take = req_i & allow_q;
  assign wrap = (slot_q == `MT_WINDOW_LAST);
  assign used_d = wrap ? 4'h0 : used_q + {3'h0, take};
  assign allow_o = allow_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_q <= 3'h0;
    end else begin
      slot_q <= slot_q + 3'h1;
    end
  end

  // a new window starts with an empty count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      used_q <= 4'h0;
      allow_q <= 1'b1;
    end else begin
      used_q <= used_d;
      allow_q <= (used_d < budget_i);
    end
  end

  a_window_budget: assert property (@(posedge clk_i) disable iff (rst_i)
    allow_o && $stable(budget_i) |-> used_q < budget_i)
    else $error("transfer allowed beyond window budget");

  a_window_reopen: assert property (@(posedge clk_i) disable iff (rst_i)
    slot_q == 3'h0 && $stable(budget_i) && budget_i != 4'h0 |-> allow_o)
    else $error("new window did not reopen transfers");

endmodule : throttle_window
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the throttle and capability registers
`include "mem_throttle_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] sel_i = 4'h0;
  logic ack_o;
  logic [31:0] dat_o;
  mem_throttle_pkg::cap_fuse_s fuse_i = 4'hF;
  logic mode_sel = 1'b0;
  logic rd_req_i = 1'b0;
  logic wr_req_i = 1'b0;
  logic rd_allow_o;
  logic wr_allow_o;
  logic gtt_32mb_o;
  mem_throttle_pkg::misc_cfg_s cfg_o;
  int num_errors = 0;
  int n_compared = 0;
  int nr;
  int nw;
  int rbud[4] = '{8, 7, 6, 5};
  int wbud[4] = '{8, 5, 4, 3};
  logic [31:0] seed = 32'h00000022;
  logic [31:0] rd;
  logic [31:0] r;
  logic [7:0] mdl = 8'h00;
  localparam logic [11:0] MISC_A = {`MT_MISC_IDX, 2'b00};
  localparam logic [11:0] CAP_A = {`MT_CAPABILITY_IDENTIFICATION_IDX, 2'b00};

  mem_throttle_regs u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .dat_o(dat_o),
    .fuse_i(fuse_i), .agp_graphics_mode_control_i(mode_sel),
    .rd_req_i(rd_req_i), .wr_req_i(wr_req_i), .rd_allow_o(rd_allow_o),
    .wr_allow_o(wr_allow_o), .cfg_o(cfg_o), .gtt_32mb_o(gtt_32mb_o)
  );

  always #25 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // one classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic wr_misc(input logic [7:0] v, input logic s0);
    logic [31:0] x;
    x = xs();
    wb(1'b1, MISC_A, {x[31:8], v}, {x[3:1], s0});
    if (s0) begin
      if (!mdl[3]) mdl[7:3] = v[7:3];
      mdl[1:0] = v[1:0];
    end
    chk({25'h0000000, cfg_o}, {25'h0000000, mdl[7:3], mdl[1:0]});
  endtask : wr_misc

  task automatic rd_misc();
    wb(1'b0, MISC_A, xs(), 4'hF);
    chk(rd, {24'h000000, mdl});
  endtask : rd_misc

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl = 8'h00;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    do_reset();
    rd_misc();
    wb(1'b0, CAP_A, xs(), 4'hF);
    chk(rd, 32'hF104A009);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      mode_sel <= i[1];
      wr_misc({i[1:0], i[1:0], 2'b00, i[0], ~i[0]}, 1'b1);
      rd_misc();
      rd_req_i <= 1'b1;
      wr_req_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      nr = 0;
      nw = 0;
      repeat (64) begin
        @(negedge clk_i);
        nr += int'(rd_allow_o === 1'b1);
        nw += int'(wr_allow_o === 1'b1);
      end
      chk(nr, 8 * rbud[i]);
      chk(nw, 8 * wbud[i]);
      chk({31'h00000000, gtt_32mb_o}, {31'h00000000, ~i[0] & i[1]});
      @(posedge clk_i);
      rd_req_i <= 1'b0;
      wr_req_i <= 1'b0;
    end
    $display("test throttle done");
    for (int i = 0; i < 6; i++) begin
      r = xs();
      fuse_i <= r[3:0];
      mode_sel <= i[0];
      repeat (4) @(posedge clk_i);
      wb(1'b1, CAP_A, r, 4'hF);
      wb(1'b0, CAP_A, xs(), 4'hF);
      chk(rd, {r[3:0], 4'h1, 8'h04, i[0] ? 8'h00 : 8'hA0, 8'h09});
    end
    wb(1'b0, 12'h004, xs(), 4'hF);
    chk(rd, 32'h00000000);
    $display("test capability done");
    wr_misc(8'h18, 1'b1);
    wr_misc(8'hA3, 1'b1);
    wr_misc(8'h00, 1'b1);
    wr_misc(8'hFF, 1'b0);
    rd_misc();
    do_reset();
    rd_misc();
    wr_misc(8'h20, 1'b1);
    rd_misc();
    $display("test lock done");
    test_done();
  end
endmodule : tb
`default_nettype wire
